// >>> tbs_consts.svh
`ifndef TBS_CONSTS_SVH
`define TBS_CONSTS_SVH
// Widths and counts
`define TBS_CW 16
`define TBS_NS 4
`define TBS_SEL_W 2
`define TBS_AW 8
`define TBS_SLOTS 16
`define TBS_POS_W 7
`define TBS_IRQ_W 3
// Register byte addresses and address groups
`define TBS_A_CTRL 8'h00
`define TBS_A_TTHR 8'h04
`define TBS_A_MAXD 8'h08
`define TBS_A_STEPS 8'h0c
`define TBS_A_STAT 8'h20
`define TBS_A_ISTAT 8'h24
`define TBS_A_ICLR 8'h28
`define TBS_A_IEN 8'h2c
`define TBS_G_KTHR 4'h1
`define TBS_G_BASE 4'h3
`define TBS_G_DELTA 4'h4
// Control field positions
`define TBS_CTRL_METHOD 0
`define TBS_CTRL_AVG_LO 2
`define TBS_CTRL_AVG_HI 3
`define TBS_CTRL_DISC_LO 4
`define TBS_CTRL_DISC_HI 7
// Status field positions
`define TBS_STAT_TOUCH_LO 4
`define TBS_STAT_POS_LO 8
// Interrupt bits
`define TBS_IRQ_PRESS 0
`define TBS_IRQ_POS 1
`define TBS_IRQ_MEAS 2
// Reset values
`define TBS_RST_TTHR 16'h0008
`define TBS_RST_KTHR 16'h0040
`define TBS_RST_MAXD 16'h0100
`define TBS_RST_STEPS 5'h10
// Bus responses
`define TBS_RESP_OK 2'b00
`define TBS_RESP_ERR 2'b10
`endif

// >>> tbs_meas_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbs_consts.svh"
module tbs_meas_model
  import tbs_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic go, // Launch one result
  input wire logic [`TBS_SEL_W-1:0] sel, // Sensor measured
  input wire logic [`TBS_CW-1:0] cnt, // Counts in the window
  output logic sample_valid, // Result strobe
  output logic [`TBS_SEL_W-1:0] sample_sensor, // Sensor of result
  output logic [`TBS_CW-1:0] sample_count // Timer count result
);
  // Quiet lines before the first window
  initial begin
    sample_valid = 1'b0;
    sample_sensor = '0;
    sample_count = '0;
  end
  // One strobe per window; lines scramble between results so stale data is not trusted
  always @(posedge aclk) begin
    sample_valid <= go;
    if (go) begin
      sample_sensor <= sel;
      sample_count <= cnt;
    end else begin
      sample_sensor <= ~sample_sensor;
      sample_count <= ~sample_count;
    end
  end
endmodule
`default_nettype wire

// >>> tbs_pkg.sv
package tbs_pkg;
`include "tbs_consts.svh"

  // Bus channel phase, Gray coded
  typedef enum logic [1:0] {
    TBS_IDLE = 2'b00,
    TBS_RESP = 2'b01
  } tbs_bus_e;

  typedef logic [`TBS_CW-1:0] tbs_cnt_t;

  // Top-level state
  typedef struct packed {
    tbs_bus_e wst;
    logic aw_held;
    logic [`TBS_AW-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    tbs_bus_e rph;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic method;
    logic [1:0] avg;
    logic [3:0] disc;
    tbs_cnt_t tthr;
    tbs_cnt_t maxd;
    logic [4:0] steps;
    logic [`TBS_NS-1:0][`TBS_CW-1:0] kthr;
    logic [`TBS_IRQ_W-1:0] ist;
    logic [`TBS_IRQ_W-1:0] ien;
    logic [`TBS_NS-1:0] prev_press;
    logic [`TBS_POS_W-1:0] prev_pos;
  } tbs_top_s;

  // Per-sensor tracker state
  typedef struct packed {
    logic [`TBS_CW+2:0] acc;
    logic [3:0] n;
    tbs_cnt_t base;
    logic base_ok;
    tbs_cnt_t delta;
    logic touched;
    logic pressed;
    logic upd;
  } tbs_trk_s;

  // Slider state
  typedef struct packed {
    logic [`TBS_POS_W-1:0] pos;
  } tbs_sld_s;
endpackage

// >>> tbs_slider.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbs_consts.svh"
module tbs_slider
  import tbs_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [`TBS_NS-1:0] touched, // Touched sensors
  input wire logic [`TBS_NS-1:0][`TBS_CW-1:0] delta, // Clamped deltas
  input wire logic [`TBS_CW-1:0] max_delta, // Delta ceiling
  input wire logic [4:0] steps, // Steps per key
  output logic [`TBS_POS_W-1:0] pos // Slider position
);
  tbs_sld_s s_reg, s_next;

  // Local step within one key, 1 to 16
  function automatic logic [4:0] local_step(input logic [`TBS_CW-1:0] d,
                                            input logic [`TBS_CW-1:0] maxd,
                                            input logic [4:0] st);
    logic [`TBS_CW-1:0] sz;
    logic [`TBS_CW-1:0] q;
    sz = maxd / {11'h0, (st == 5'h0) ? 5'h1 : st}; // RULE_13
    if (sz == '0) sz = `TBS_CW'(1);
    q = d / sz; // RULE_18
    if (q < `TBS_CW'(1)) return 5'h1; // RULE_18
    if (q > `TBS_CW'(`TBS_SLOTS)) return 5'(`TBS_SLOTS); // RULE_17 RULE_18
    return q[4:0];
  endfunction

  // Highest touched sensor overrides lower ones
  always_comb begin
    s_next.pos = '0; // RULE_14
    for (int i = 0; i < `TBS_NS; i++) begin
      if (touched[i]) begin
        s_next.pos = `TBS_POS_W'(i * `TBS_SLOTS) + {2'h0, local_step(delta[i], max_delta, steps)}; // RULE_11 RULE_15 RULE_16
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pos = s_reg.pos;
endmodule
`default_nettype wire

// >>> tbs_top.sv
// How it works
// RULE_01 - A configurable count of low raw-count bits is dropped before use.
// RULE_02 - One to eight consecutive samples per sensor may be averaged first.
// RULE_03 - Every sensor holds its own baseline, fed only by its own samples.
// RULE_04 - Delta sign follows method: oscillator counts fall, resistor counts rise.
// RULE_05 - Each result is first checked against a small presence threshold.
// RULE_06 - Baseline changes only while the sensor reads as untouched.
// RULE_07 - Lower-capacitance result: baseline becomes mean of old and new.
// RULE_08 - Higher-capacitance result: baseline moves one count toward it.
// RULE_09 - Key is pressed when its delta exceeds its own programmable threshold.
// RULE_10 - Software sets press thresholds above measurement noise.
// RULE_11 - Four sensors of sixteen positions give sixty-four slider steps.
// RULE_12 - Each delta is clamped to a configured reachable maximum.
// RULE_13 - Step size is maximum delta over steps per key.
// RULE_14 - Position is zero while no sensor is touched.
// RULE_15 - Only the most significant touched sensor sets the position.
// RULE_16 - Sensor weight times sixteen plus local step gives 1 to 64.
// RULE_17 - A saturated sensor holds position until a higher one is touched.
// RULE_18 - Local step is delta over step size, limited to 1..16.
// RULE_19 - Incoming raw counts are timer counts over one measurement window.
`timescale 1ns/1ns
`default_nettype none
`include "tbs_consts.svh"
module tbs_top
  import tbs_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [`TBS_AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [`TBS_AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic sample_valid, // Raw count strobe
  input wire logic [`TBS_SEL_W-1:0] sample_sensor, // Sensor of the count
  input wire logic [`TBS_CW-1:0] sample_count, // Raw timer count
  output logic [`TBS_NS-1:0] key_pressed, // Pressed keys
  output logic [`TBS_NS-1:0] key_touched, // Touched keys
  output logic [`TBS_POS_W-1:0] slider_pos, // Slider position
  output logic irq // Level interrupt
);
  tbs_top_s s_reg, s_next;
  logic [`TBS_NS-1:0][`TBS_CW-1:0] base_w;
  logic [`TBS_NS-1:0][`TBS_CW-1:0] delta_w;
  logic [`TBS_NS-1:0] touch_w, press_w, upd_w;
  logic [`TBS_POS_W-1:0] pos_w;
  logic [32:0] wr_cur, rd_cur;
  logic [31:0] nv;
  logic [`TBS_IRQ_W-1:0] clr, set;

  // Register read mux: bit 32 flags a mapped address
  function automatic logic [32:0] reg_read(input logic [`TBS_AW-1:0] a);
    logic [1:0] ix;
    ix = a[3:2];
    case (a)
      `TBS_A_CTRL: return {1'b1, 24'h0, s_reg.disc, s_reg.avg, 1'b0, s_reg.method};
      `TBS_A_TTHR: return {1'b1, 16'h0, s_reg.tthr};
      `TBS_A_MAXD: return {1'b1, 16'h0, s_reg.maxd};
      `TBS_A_STEPS: return {1'b1, 27'h0, s_reg.steps};
      `TBS_A_STAT: return {1'b1, 17'h0, pos_w, touch_w, press_w};
      `TBS_A_ISTAT: return {1'b1, 29'h0, s_reg.ist};
      `TBS_A_ICLR: return {1'b1, 32'h0};
      `TBS_A_IEN: return {1'b1, 29'h0, s_reg.ien};
      default: begin
        if (a[1:0] != 2'h0) return {1'b0, 32'h0};
        if (a[7:4] == `TBS_G_KTHR) return {1'b1, 16'h0, s_reg.kthr[ix]};
        if (a[7:4] == `TBS_G_BASE) return {1'b1, 16'h0, base_w[ix]};
        if (a[7:4] == `TBS_G_DELTA) return {1'b1, 16'h0, delta_w[ix]};
        return {1'b0, 32'h0};
      end
    endcase
  endfunction

  // Byte-lane merge of a write into the current word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction

  // Writes to read-only words are refused so software sees its mistake
  function automatic logic writable(input logic [`TBS_AW-1:0] a);
    case (a)
      `TBS_A_CTRL, `TBS_A_TTHR, `TBS_A_MAXD, `TBS_A_STEPS: return 1'b1;
      `TBS_A_ICLR, `TBS_A_IEN: return 1'b1;
      default: return (a[7:4] == `TBS_G_KTHR) && (a[1:0] == 2'h0);
    endcase
  endfunction

  // Bus slave, configuration, event capture
  always_comb begin
    s_next = s_reg;
    clr = '0;
    wr_cur = reg_read(s_reg.awaddr);
    rd_cur = reg_read(s_axi_araddr);
    nv = wmerge(wr_cur[31:0], s_reg.wdata, s_reg.wstrb);
    // Address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_held = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    case (s_reg.wst)
      TBS_IDLE: begin
        if (s_reg.aw_held && s_reg.w_held) begin
          s_next.aw_held = 1'b0;
          s_next.w_held = 1'b0;
          s_next.wst = TBS_RESP;
          s_next.bresp = writable(s_reg.awaddr) ? `TBS_RESP_OK : `TBS_RESP_ERR;
          case (s_reg.awaddr)
            `TBS_A_CTRL: begin
              s_next.method = nv[`TBS_CTRL_METHOD];
              s_next.avg = nv[`TBS_CTRL_AVG_HI:`TBS_CTRL_AVG_LO];
              s_next.disc = nv[`TBS_CTRL_DISC_HI:`TBS_CTRL_DISC_LO];
            end
            `TBS_A_TTHR: s_next.tthr = nv[`TBS_CW-1:0];
            `TBS_A_MAXD: s_next.maxd = nv[`TBS_CW-1:0];
            `TBS_A_STEPS: s_next.steps = nv[4:0];
            `TBS_A_ICLR: clr = nv[`TBS_IRQ_W-1:0];
            `TBS_A_IEN: s_next.ien = nv[`TBS_IRQ_W-1:0];
            default: begin
              if (writable(s_reg.awaddr)) s_next.kthr[s_reg.awaddr[3:2]] = nv[`TBS_CW-1:0];
            end
          endcase
        end
      end
      TBS_RESP: begin
        if (s_axi_bready) s_next.wst = TBS_IDLE;
      end
      default: s_next.wst = TBS_IDLE;
    endcase
    // Read channel
    case (s_reg.rph)
      TBS_IDLE: begin
        if (s_axi_arvalid) begin
          s_next.rph = TBS_RESP;
          s_next.rdata = rd_cur[31:0];
          s_next.rresp = rd_cur[32] ? `TBS_RESP_OK : `TBS_RESP_ERR;
        end
      end
      TBS_RESP: begin
        if (s_axi_rready) s_next.rph = TBS_IDLE;
      end
      default: s_next.rph = TBS_IDLE;
    endcase
    // Sticky events; a new event beats a clear in the same cycle
    set = '0;
    set[`TBS_IRQ_PRESS] = |(press_w ^ s_reg.prev_press);
    set[`TBS_IRQ_POS] = pos_w != s_reg.prev_pos;
    set[`TBS_IRQ_MEAS] = |upd_w;
    s_next.ist = (s_reg.ist & ~clr) | set;
    s_next.prev_press = press_w;
    s_next.prev_pos = pos_w;
  end

  // State register with documented defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.tthr <= `TBS_RST_TTHR;
      s_reg.maxd <= `TBS_RST_MAXD;
      s_reg.steps <= `TBS_RST_STEPS;
      s_reg.kthr <= {`TBS_NS{`TBS_RST_KTHR}};
    end else begin
      s_reg <= s_next;
    end
  end

  // Handshakes; one write and one read in flight
  assign s_axi_awready = !s_reg.aw_held && (s_reg.wst == TBS_IDLE);
  assign s_axi_wready = !s_reg.w_held && (s_reg.wst == TBS_IDLE);
  assign s_axi_bvalid = s_reg.wst == TBS_RESP;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.rph == TBS_IDLE;
  assign s_axi_rvalid = s_reg.rph == TBS_RESP;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign irq = |(s_reg.ist & s_reg.ien);
  assign key_pressed = press_w;
  assign key_touched = touch_w;
  assign slider_pos = pos_w;

  // One tracker per sensor, steered only by its own samples
  for (genvar g = 0; g < `TBS_NS; g++) begin : g_trk
    tbs_track u_trk (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_valid(sample_valid && (sample_sensor == `TBS_SEL_W'(g))), // RULE_03
      .sample_count(sample_count),
      .method(s_reg.method),
      .avg_log2(s_reg.avg),
      .discard_bits(s_reg.disc),
      .touch_thr(s_reg.tthr),
      .key_thr(s_reg.kthr[g]),
      .max_delta(s_reg.maxd),
      .base_out(base_w[g]),
      .delta_out(delta_w[g]),
      .touched(touch_w[g]),
      .pressed(press_w[g]),
      .upd(upd_w[g])
    );

    chk_own_base: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
      $changed(base_w[g]) |-> $past(sample_valid && (sample_sensor == `TBS_SEL_W'(g))))
      else $error("baseline moved without own sample");
    chk_press_thr: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
      upd_w[g] |-> press_w[g] == (delta_w[g] > $past(s_reg.kthr[g])))
      else $error("press flag disagrees with threshold");
    chk_delta_clamp: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_12
      upd_w[g] |-> delta_w[g] <= $past(s_reg.maxd))
      else $error("delta above maximum");
  end

  tbs_slider u_sld (
    .aclk(aclk),
    .aresetn(aresetn),
    .touched(touch_w),
    .delta(delta_w),
    .max_delta(s_reg.maxd),
    .steps(s_reg.steps),
    .pos(pos_w)
  );

  chk_pos_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_14
    touch_w == '0 |=> pos_w == '0)
    else $error("position not zero when idle");
  chk_pos_range: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_16
    touch_w != '0 |=> pos_w >= `TBS_POS_W'(1) && pos_w <= `TBS_POS_W'(4 * `TBS_SLOTS))
    else $error("position out of range");
  chk_top_key: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_15
    touch_w[`TBS_NS-1] |=> pos_w > `TBS_POS_W'(3 * `TBS_SLOTS))
    else $error("top sensor not dominant");
  chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (|upd_w) |=> s_reg.ist[`TBS_IRQ_MEAS])
    else $error("measure event lost");
  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  cov_press: cover property (@(posedge aclk) disable iff (!aresetn) $rose(|press_w));
  cov_top_pos: cover property (@(posedge aclk) disable iff (!aresetn)
    pos_w == `TBS_POS_W'(4 * `TBS_SLOTS));
  cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule
`default_nettype wire

// >>> tbs_track.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbs_consts.svh"
module tbs_track
  import tbs_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, low
  input wire logic sample_valid, // Raw count for this sensor
  input wire logic [`TBS_CW-1:0] sample_count, // Raw count
  input wire logic method, // 1 = resistor charge
  input wire logic [1:0] avg_log2, // Samples averaged, log2
  input wire logic [3:0] discard_bits, // Low bits dropped
  input wire logic [`TBS_CW-1:0] touch_thr, // Presence threshold
  input wire logic [`TBS_CW-1:0] key_thr, // Press threshold
  input wire logic [`TBS_CW-1:0] max_delta, // Delta ceiling
  output logic [`TBS_CW-1:0] base_out, // Tracked baseline
  output logic [`TBS_CW-1:0] delta_out, // Clamped delta
  output logic touched, // At or above presence threshold
  output logic pressed, // Above press threshold
  output logic upd // One-cycle update pulse
);
  tbs_trk_s s_reg, s_next;
  logic [`TBS_CW+2:0] sum;
  logic [3:0] n_inc;
  logic proc, lower_cap, higher_cap, quiet;
  logic [`TBS_CW-1:0] meas, raw_d, avg_v;

  // Average, shift, compare, then track the baseline
  always_comb begin
    s_next = s_reg;
    s_next.upd = 1'b0;
    sum = s_reg.acc + {3'h0, sample_count}; // RULE_19
    n_inc = s_reg.n + 4'h1;
    proc = sample_valid && (n_inc >= (4'h1 << avg_log2)); // RULE_02
    meas = `TBS_CW'(sum >> avg_log2) >> discard_bits; // RULE_01
    lower_cap = method ? (meas < s_reg.base) : (meas > s_reg.base); // RULE_04
    higher_cap = method ? (meas > s_reg.base) : (meas < s_reg.base); // RULE_04
    raw_d = !higher_cap ? '0 : (method ? meas - s_reg.base : s_reg.base - meas); // RULE_04
    quiet = raw_d < touch_thr; // RULE_05
    avg_v = `TBS_CW'(({1'b0, s_reg.base} + {1'b0, meas}) >> 1);
    if (sample_valid) begin
      s_next.acc = proc ? '0 : sum;
      s_next.n = proc ? '0 : n_inc;
    end
    if (proc) begin
      s_next.upd = 1'b1;
      if (!s_reg.base_ok) begin
        // First result seeds the baseline
        s_next.base = meas;
        s_next.base_ok = 1'b1;
        s_next.delta = '0;
        s_next.touched = 1'b0;
        s_next.pressed = 1'b0;
      end else begin
        s_next.delta = (raw_d > max_delta) ? max_delta : raw_d; // RULE_12
        s_next.touched = !quiet;
        s_next.pressed = s_next.delta > key_thr; // RULE_09
        // Slow one-count creep toward higher capacitance so an approaching finger is not absorbed
        if (quiet && lower_cap) begin
          s_next.base = avg_v; // RULE_06 RULE_07
        end else if (quiet && higher_cap) begin
          s_next.base = method ? s_reg.base + 1'b1 : s_reg.base - 1'b1; // RULE_06 RULE_08
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign base_out = s_reg.base;
  assign delta_out = s_reg.delta;
  assign touched = s_reg.touched;
  assign pressed = s_reg.pressed;
  assign upd = s_reg.upd;

  chk_base_avg: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_07
    proc && s_reg.base_ok && quiet && lower_cap |=> s_reg.base == $past(avg_v))
    else $error("baseline not averaged down");
  chk_base_step: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    proc && s_reg.base_ok && quiet && higher_cap |=>
      s_reg.base == ($past(method) ? $past(s_reg.base) + 1'b1 : $past(s_reg.base) - 1'b1))
    else $error("baseline not moved by one count");
endmodule
`default_nettype wire

// >>> touch_baseline_slider_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbs_consts.svh"
module touch_baseline_slider_logic_tb
  import tbs_pkg::*;
;
  localparam logic [7:0] B0 = {`TBS_G_BASE, 4'h0};
  localparam logic [7:0] D0 = {`TBS_G_DELTA, 4'h0};
  localparam logic [1:0] OK = `TBS_RESP_OK;
  localparam logic [1:0] ER = `TBS_RESP_ERR;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sample_valid, irq, go;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, key_pressed, key_touched;
  logic [1:0] bresp, rresp, sample_sensor, sel;
  logic [15:0] sample_count, cnt;
  logic [6:0] slider_pos;
  int bad_count, comparisons;

  tbs_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sample_valid(sample_valid), .sample_sensor(sample_sensor),
    .sample_count(sample_count), .key_pressed(key_pressed), .key_touched(key_touched),
    .slider_pos(slider_pos), .irq(irq));
  tbs_meas_model i_model (.aclk(aclk), .go(go), .sel(sel), .cnt(cnt),
    .sample_valid(sample_valid), .sample_sensor(sample_sensor),
    .sample_count(sample_count));

  // Generic comparison; unknowns never match
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      if (aw && w && bvalid === 1'b1) begin
        b = 1'b1;
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
    chk("bvalid", 32'h1, {31'h0, b});
  endtask

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    ar = 1'b0;
    r = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !r; n++) begin
      @(posedge aclk);
      if (!ar && arready === 1'b1) begin
        ar = 1'b1;
        arvalid <= 1'b0;
      end else if (ar && rvalid === 1'b1) begin
        r = 1'b1;
        rready <= 1'b0;
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
    chk("rvalid", 32'h1, {31'h0, r});
  endtask

  // One result from the far side, then the fixed pipeline depth plus margin
  task automatic send(input logic [1:0] s, input logic [15:0] c);
    @(posedge aclk);
    go <= 1'b1;
    sel <= s;
    cnt <= c;
    @(posedge aclk);
    go <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask

  task automatic t_reset;
    chk("slider_pos", 32'h0, {25'h0, slider_pos});
    rd(`TBS_A_CTRL, 32'h0, OK);
    rd(`TBS_A_TTHR, {16'h0, `TBS_RST_TTHR}, OK);
    rd(`TBS_A_MAXD, {16'h0, `TBS_RST_MAXD}, OK);
    rd(`TBS_A_STEPS, {27'h0, `TBS_RST_STEPS}, OK);
    rd({`TBS_G_KTHR, 4'h4}, {16'h0, `TBS_RST_KTHR}, OK);
    rd(8'h50, 32'h0, ER);
    wr(`TBS_A_STAT, 32'h1, ER);
    rd(`TBS_A_STAT, 32'h0, OK);
  endtask

  task automatic t_track;
    send(2'd0, 16'd1000);
    rd(B0, 32'd1000, OK);
    send(2'd0, 16'd1004);
    rd(B0, 32'd1002, OK);
    send(2'd0, 16'd998);
    rd(B0, 32'd1001, OK);
    send(2'd0, 16'd991);
    rd(B0, 32'd1001, OK);
    rd(D0, 32'd10, OK);
    chk("key_touched", 32'h1, {28'h0, key_touched});
    chk("slider_pos", 32'd1, {25'h0, slider_pos});
    rd(B0 + 8'h4, 32'h0, OK);
  endtask

  task automatic t_slider;
    send(2'd2, 16'd1000);
    send(2'd2, 16'd872);
    chk("key_pressed", 32'h4, {28'h0, key_pressed});
    chk("slider_pos", 32'd40, {25'h0, slider_pos});
    send(2'd2, 16'd936);
    chk("key_pressed", 32'h0, {28'h0, key_pressed});
    chk("slider_pos", 32'd36, {25'h0, slider_pos});
    send(2'd2, 16'd935);
    chk("key_pressed", 32'h4, {28'h0, key_pressed});
    send(2'd2, 16'd600);
    rd(D0 + 8'h8, 32'h100, OK);
    chk("slider_pos", 32'd48, {25'h0, slider_pos});
    send(2'd2, 16'd500);
    chk("slider_pos", 32'd48, {25'h0, slider_pos});
  endtask

  task automatic t_resist;
    wr(`TBS_A_CTRL, 32'h1, OK);
    wr({`TBS_G_KTHR, 4'hc}, 32'h50, OK);
    rd({`TBS_G_KTHR, 4'hc}, 32'h50, OK);
    send(2'd3, 16'd500);
    send(2'd3, 16'd600);
    chk("slider_pos", 32'd54, {25'h0, slider_pos});
    chk("key_pressed", 32'hc, {28'h0, key_pressed});
    send(2'd3, 16'd497);
    rd(B0 + 8'hc, 32'd498, OK);
    chk("slider_pos", 32'd48, {25'h0, slider_pos});
    wr(`TBS_A_STEPS, 32'h8, OK);
    rd(`TBS_A_STEPS, 32'h8, OK);
    chk("slider_pos", 32'd40, {25'h0, slider_pos});
  endtask

  task automatic t_avg;
    wr(`TBS_A_CTRL, 32'h44, OK);
    send(2'd1, 16'h1000);
    rd(B0 + 8'h4, 32'h0, OK);
    send(2'd1, 16'h1002);
    rd(B0 + 8'h4, 32'h100, OK);
  endtask

  task automatic t_irq;
    wr(`TBS_A_CTRL, 32'h0, OK);
    rd(`TBS_A_ISTAT, 32'h7, OK);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`TBS_A_IEN, 32'h7, OK);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`TBS_A_ICLR, 32'h7, OK);
    rd(`TBS_A_ISTAT, 32'h0, OK);
    chk("irq", 32'h0, {31'h0, irq});
    send(2'd1, 16'h0100);
    rd(`TBS_A_ISTAT, 32'h4, OK);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`TBS_A_IEN, 32'h3, OK);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // 125 MHz system clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Whole run is a few hundred cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata, wstrb, sel, cnt} = '0;
    bad_count = 0;
    comparisons = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_track();
    t_slider();
    t_resist();
    t_avg();
    t_irq();
    // Mid-run reset must bring every setting back to its default
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
